// ===== design/cwp_cfg.svh
// Offsets, field positions and reset values of the protection configuration block
`ifndef CWP_CFG_SVH
`define CWP_CFG_SVH
`define CWP_OFS_READ_GUARD 32'h00300009
`define CWP_OFS_WRITE_LOCK 32'h0030000a
`define CWP_OFS_STATUS 32'h00000010
`define CWP_OFS_VARIANT 32'h00000014
`define CWP_BIT_EEPROM_GUARD 7
`define CWP_BIT_BOOT_GUARD 6
`define CWP_BIT_SEG3_LOCK 3
`define CWP_RST_READ_GUARD 8'hc0
`define CWP_RST_WRITE_LOCK 8'hff
`define CWP_MASK_READ_GUARD 8'hc0
`define CWP_BOOT_END_SMALL 24'h0007ff
`define CWP_BOOT_END_LARGE 24'h0001ff
`define CWP_SEG3_START 24'h00c000
`define CWP_SEG3_END 24'h00ffff
`endif

// ===== design/cwp_pkg.sv
// Types shared by the protection configuration block
package cwp_pkg;
	typedef struct packed {
		logic [23:0] addr;
		logic valid;
	} cwp_req_t;
	typedef struct packed {
		logic eeprom_read_deny;
		logic boot_read_deny;
		logic seg3_write_deny;
	} cwp_qual_t;
endpackage

// ===== design/cwp_decode.sv
// Address qualifier decode for the protection configuration block
`timescale 1ns/100ps
`default_nettype none
`include "cwp_cfg.svh"
module cwp_decode
	import cwp_pkg::*;
(
	input wire logic [7:0] read_guard_byte,
	input wire logic [7:0] segment_write_lock_byte,
	input wire logic large_variant,
	input wire cwp_req_t code_req,
	output logic code_in_boot,
	output logic code_in_seg3,
	output cwp_qual_t qual
);
	logic [23:0] boot_end;
	// Boot block limit depends on variant
	assign boot_end = large_variant ? `CWP_BOOT_END_LARGE : `CWP_BOOT_END_SMALL; // see [RL2]
	assign code_in_boot = code_req.valid && (code_req.addr <= boot_end);
	assign code_in_seg3 = code_req.valid && large_variant && (code_req.addr >= `CWP_SEG3_START)
		&& (code_req.addr <= `CWP_SEG3_END);
	// Qualifiers: zero bit means protected
	assign qual.eeprom_read_deny = ~read_guard_byte[`CWP_BIT_EEPROM_GUARD]; // see [RL1]
	assign qual.boot_read_deny = code_in_boot & ~read_guard_byte[`CWP_BIT_BOOT_GUARD]; // see [RL2]
	assign qual.seg3_write_deny = code_in_seg3 &
		~segment_write_lock_byte[`CWP_BIT_SEG3_LOCK]; // see [RL5]
endmodule
`default_nettype wire

// ===== design/cwp_top.sv
// APB register block holding the memory protection configuration bytes
`timescale 1ns/100ps
`default_nettype none
`include "cwp_cfg.svh"
// Function
// [RL1] EEPROM guard bit 7 zero makes data EEPROM read protected
// [RL2] Boot guard bit 6 zero protects boot block, end depends on variant
// [RL3] Read guard bits 5 to 0 always read zero
// [RL4] Read guard settings live at byte address 300009h
// [RL5] Lock bit 3 zero blocks writes to segment 3 on large variants
// [RL6] Guard bits reset to one and only clear, never set by writes
module cwp_top
	import cwp_pkg::*;
#(
	parameter logic LARGE_VARIANT = 1'b1
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire cwp_req_t code_req,
	output cwp_qual_t qual
);
	typedef struct packed {
		logic [7:0] read_guard_byte;
		logic [7:0] segment_write_lock_byte;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		cwp_qual_t qual;
	} cwp_state_t;

	cwp_state_t r;
	cwp_state_t next_r;
	cwp_qual_t comb_qual;
	logic in_boot;
	logic in_seg3;

	// Byte addresses are printed directly, so decode the full offset
	function automatic logic [2:0] cwp_sel(input logic [31:0] a);
		logic [2:0] s;
		s = 3'h0;
		case ({a[31:2], 2'b00})
			(`CWP_OFS_READ_GUARD & 32'hfffffffc): s = 3'h1; // see [RL4]
			default: s = 3'h0;
		endcase
		if (a == `CWP_OFS_WRITE_LOCK) s = 3'h2;
		if (a == `CWP_OFS_STATUS) s = 3'h3;
		if (a == `CWP_OFS_VARIANT) s = 3'h4;
		if ((a != `CWP_OFS_READ_GUARD) && (s == 3'h1)) s = 3'h0;
		return s;
	endfunction

	cwp_decode u_dec (
		.read_guard_byte(r.read_guard_byte),
		.segment_write_lock_byte(r.segment_write_lock_byte),
		.large_variant(LARGE_VARIANT),
		.code_req(code_req),
		.code_in_boot(in_boot),
		.code_in_seg3(in_seg3),
		.qual(comb_qual)
	);

	logic [2:0] sel;
	logic setup;
	assign sel = cwp_sel(paddr);
	assign setup = psel && !penable;

	// Next state: single-cycle APB access, answer ready on the access cycle
	always_comb
	begin
		next_r = r;
		next_r.qual = comb_qual;
		next_r.pready = 1'b0;
		next_r.pslverr = 1'b0;
		if (setup)
		begin
			next_r.pready = 1'b1;
			next_r.pslverr = (sel == 3'h0);
			next_r.prdata = 32'h00000000;
			if (pwrite)
			begin
				if (sel == 3'h1 && pstrb[0])
					// Only clears, masked to implemented bits
					next_r.read_guard_byte = r.read_guard_byte & (pwdata[7:0] |
						~`CWP_MASK_READ_GUARD) & `CWP_MASK_READ_GUARD; // see [RL6] see [RL3]
				if (sel == 3'h2 && pstrb[0])
					next_r.segment_write_lock_byte = pwdata[7:0]; // see [RL5]
				if (sel == 3'h3 || sel == 3'h4)
					next_r.pslverr = 1'b1;
			end
			else
			begin
				case (sel)
					3'h1: next_r.prdata = {24'h000000, r.read_guard_byte &
						`CWP_MASK_READ_GUARD}; // see [RL3]
					3'h2: next_r.prdata = {24'h000000, r.segment_write_lock_byte};
					3'h3: next_r.prdata = {27'h0000000, in_seg3, in_boot, comb_qual};
					3'h4: next_r.prdata = {31'h00000000, LARGE_VARIANT};
					default: next_r.prdata = 32'h00000000;
				endcase
			end
		end
	end

	// State register, unprogrammed defaults at reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r.read_guard_byte <= `CWP_RST_READ_GUARD; // see [RL6]
			r.segment_write_lock_byte <= `CWP_RST_WRITE_LOCK;
			r.prdata <= 32'h00000000;
			r.pready <= 1'b0;
			r.pslverr <= 1'b0;
			r.qual <= '0;
		end
		else
			r <= next_r;
	end

	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign qual = r.qual;

	// Guard bits never rise without reset
	guard_clear_only_a: assert property (@(posedge pclk) disable iff (!presetn) // see [RL6]
		!$rose(r.read_guard_byte[`CWP_BIT_EEPROM_GUARD])
		&& !$rose(r.read_guard_byte[`CWP_BIT_BOOT_GUARD]))
		else $error("guard bit set by write");
	low_bits_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // see [RL3]
		r.read_guard_byte[5:0] == 6'h00)
		else $error("unimplemented guard bits nonzero");
	eeprom_deny_a: assert property (@(posedge pclk) disable iff (!presetn) // see [RL1]
		qual.eeprom_read_deny == !$past(r.read_guard_byte[`CWP_BIT_EEPROM_GUARD]))
		else $error("eeprom qualifier wrong");
	boot_deny_a: assert property (@(posedge pclk) disable iff (!presetn) // see [RL2]
		qual.boot_read_deny == ($past(in_boot) && !$past(r.read_guard_byte[`CWP_BIT_BOOT_GUARD])))
		else $error("boot qualifier wrong");
	seg3_deny_a: assert property (@(posedge pclk) disable iff (!presetn) // see [RL5]
		qual.seg3_write_deny == ($past(in_seg3) &&
			!$past(r.segment_write_lock_byte[`CWP_BIT_SEG3_LOCK])))
		else $error("segment 3 qualifier wrong");
	guard_addr_a: assert property (@(posedge pclk) disable iff (!presetn) // see [RL4]
		(setup && pwrite && pstrb[0] && paddr != `CWP_OFS_READ_GUARD)
		|=> r.read_guard_byte == $past(r.read_guard_byte))
		else $error("guard changed by other address");
	read_guard_a: assert property (@(posedge pclk) disable iff (!presetn) // see [RL3]
		(setup && !pwrite && paddr == `CWP_OFS_READ_GUARD)
		|=> (prdata[31:8] == 24'h000000) && (prdata[5:0] == 6'h00))
		else $error("guard read shows low bits");
	// Setup cycle of a transfer and its one-cycle answer
	sequence cwp_setup_s;
		psel && !penable;
	endsequence
	sequence cwp_answer_s;
		pready ##1 !pready;
	endsequence
	// Every setup gets exactly one ready pulse
	apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
		cwp_setup_s |=> cwp_answer_s)
		else $error("pready not one cycle");
	// Ready only follows a setup cycle
	answer_only_a: assert property (@(posedge pclk) disable iff (!presetn)
		pready |-> $past(setup))
		else $error("pready without setup");
	// Lock byte takes the written value on a strobed write
	lock_write_a: assert property (@(posedge pclk) disable iff (!presetn) // see [RL5]
		(setup && pwrite && pstrb[0] && paddr == `CWP_OFS_WRITE_LOCK)
		|=> r.segment_write_lock_byte == $past(pwdata[7:0]))
		else $error("lock byte not written");
	// Guard write keeps only bits already set and written as one
	guard_write_a: assert property (@(posedge pclk) disable iff (!presetn) // see [RL6]
		(setup && pwrite && pstrb[0] && paddr == `CWP_OFS_READ_GUARD)
		|=> r.read_guard_byte == ($past(r.read_guard_byte) & $past(pwdata[7:0])
			& `CWP_MASK_READ_GUARD))
		else $error("guard write result wrong");
	// Writes without the low strobe leave both bytes alone
	strobe_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && pwrite && !pstrb[0])
		|=> (r.read_guard_byte == $past(r.read_guard_byte))
			&& (r.segment_write_lock_byte == $past(r.segment_write_lock_byte)))
		else $error("unstrobed write changed a byte");
	// Unmapped offsets answer with an error
	unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && sel == 3'h0) |=> pslverr)
		else $error("unmapped access without error");
	// Status and variant words are read only
	ro_write_err_a: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && pwrite && (paddr == `CWP_OFS_STATUS || paddr == `CWP_OFS_VARIANT))
		|=> pslverr)
		else $error("read-only write without error");
	// Lock byte reads back as written
	lock_read_a: assert property (@(posedge pclk) disable iff (!presetn) // see [RL5]
		(setup && !pwrite && paddr == `CWP_OFS_WRITE_LOCK)
		|=> prdata == {24'h000000, $past(r.segment_write_lock_byte)})
		else $error("lock byte read wrong");
	// Variant word shows the memory size option
	variant_read_a: assert property (@(posedge pclk) disable iff (!presetn) // see [RL2]
		(setup && !pwrite && paddr == `CWP_OFS_VARIANT)
		|=> prdata == {31'h0, LARGE_VARIANT})
		else $error("variant word wrong");
	// Boot window ends where the variant says
	boot_range_a: assert property (@(posedge pclk) disable iff (!presetn) // see [RL2]
		in_boot == (code_req.valid && (code_req.addr <=
			(LARGE_VARIANT ? `CWP_BOOT_END_LARGE : `CWP_BOOT_END_SMALL))))
		else $error("boot window wrong");
	// Segment 3 window exists on the large variant only
	seg3_range_a: assert property (@(posedge pclk) disable iff (!presetn) // see [RL5]
		in_seg3 == (code_req.valid && LARGE_VARIANT && (code_req.addr >= `CWP_SEG3_START)
			&& (code_req.addr <= `CWP_SEG3_END)))
		else $error("segment 3 window wrong");
endmodule
`default_nettype wire

// ===== verif/cwp_tb.sv
// Self-checking bench for the protection configuration block
`timescale 1ns/100ps
`default_nettype none
`include "cwp_cfg.svh"
module tb
	import cwp_pkg::*;
();
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] paddr = '0, pwdata = '0, prdata, r;
	logic [3:0] pstrb = 4'hf;
	logic pready, pslverr, e;
	cwp_req_t code_req = '0;
	cwp_qual_t qual;
	logic [7:0] g = 8'hc0, l = 8'hff, w;
	logic [23:0] a;
	int mismatches = 0, check_count = 0;
	cwp_top #(.LARGE_VARIANT(1'b1)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .code_req(code_req), .qual(qual));
	// Clock at 25 MHz
	initial
	begin
		forever #20 pclk = ~pclk;
	end
	// Expected qualifiers from guard, lock and request
	function automatic logic [31:0] exp_q(logic [7:0] gg, logic [7:0] ll, cwp_req_t q);
		logic b, s;
		b = q.valid && q.addr <= `CWP_BOOT_END_LARGE && !gg[6];
		s = q.valid && q.addr >= `CWP_SEG3_START && q.addr <= `CWP_SEG3_END && !ll[3];
		return {29'h0, !gg[7], b, s};
	endfunction
	// Expected status word: windows hit, then qualifiers
	function automatic logic [31:0] exp_st(logic [7:0] gg, logic [7:0] ll, cwp_req_t q);
		logic ib, i3;
		ib = q.valid && q.addr <= `CWP_BOOT_END_LARGE;
		i3 = q.valid && q.addr >= `CWP_SEG3_START && q.addr <= `CWP_SEG3_END;
		return {27'h0, i3, ib, 3'h0} | exp_q(gg, ll, q);
	endfunction
	task chk(input string n, input logic [31:0] x, input logic [31:0] y);
		check_count++;
		if (y !== x)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, x, y);
		end
	endtask
	// One APB transfer, held until pready
	task apb(input logic wr, input logic [31:0] ad, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Wait for the answer; only the watchdog ends a hung wait
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task report_and_stop;
		if (mismatches == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Watchdog
	initial
	begin
		#2000000;
		mismatches++;
		report_and_stop;
	end
	// Main sequence
	initial
	begin
		void'($urandom(32'h5adaf860));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `CWP_OFS_READ_GUARD, 32'h0);
		chk("guard reset", 32'hc0, r);
		apb(1'b0, `CWP_OFS_WRITE_LOCK, 32'h0);
		chk("lock reset", 32'hff, r);
		apb(1'b0, 32'h00000100, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, e});
		// Corner cases: variant word, read-only write, unstrobed write
		apb(1'b0, `CWP_OFS_VARIANT, 32'h0);
		chk("variant", 32'h1, r);
		apb(1'b1, `CWP_OFS_STATUS, 32'h0);
		chk("status write err", 32'h1, {31'h0, e});
		pstrb <= 4'he;
		apb(1'b1, `CWP_OFS_WRITE_LOCK, 32'h0);
		pstrb <= 4'hf;
		apb(1'b0, `CWP_OFS_WRITE_LOCK, 32'h0);
		chk("lock strobe", 32'hff, r);
		for (int i = 0; i < 60; i++)
		begin
			// Mid-run reset restores the unprogrammed guard
			if (i == 30)
			begin
				presetn <= 1'b0;
				repeat (5) @(posedge pclk);
				presetn <= 1'b1;
				g = 8'hc0;
			end
			if ($urandom_range(5) == 0)
			begin
				w = 8'($urandom);
				g = g & w;
				apb(1'b1, `CWP_OFS_READ_GUARD, {24'hffffff, w});
			end
			apb(1'b0, `CWP_OFS_READ_GUARD, 32'h0);
			chk("guard", {24'h0, g}, r);
			chk("guard err", 32'h0, {31'h0, e});
			l = 8'($urandom);
			apb(1'b1, `CWP_OFS_WRITE_LOCK, {24'h0, l});
			apb(1'b0, `CWP_OFS_WRITE_LOCK, 32'h0);
			chk("lock", {24'h0, l}, r);
			case ($urandom_range(3))
				0: a = 24'($urandom_range(24'h000201, 24'h0001fe));
				1: a = 24'($urandom_range(24'h00c001, 24'h00bffe));
				2: a = 24'($urandom_range(24'h010001, 24'h00fffe));
				default: a = 24'($urandom);
			endcase
			@(posedge pclk);
			code_req <= '{addr: a, valid: ($urandom_range(3) != 0)};
			repeat (3) @(posedge pclk);
			chk("qual", exp_q(g, l, code_req), {29'h0, qual});
			apb(1'b0, `CWP_OFS_STATUS, 32'h0);
			chk("status", exp_st(g, l, code_req), r);
		end
		report_and_stop;
	end
endmodule
`default_nettype wire
